//--- logic/tum_unit_map.sv
// unit number to address translation plus per-slave error log
// assumes all inputs come from logic on i_mclk; no pin synchronising needed
//
// Notes on behaviour
// - table of twenty range entries with address
// - first unit becomes remapped unit
// - range units remapped_unit remap plus offset
// - destination always chosen from unit lookup
// - each slave keeps its own error record
// - crc and timeout failures bump slave counter
// - latest exception code overwrites older one
// - good answer clears error indication itself
`include "tum_params.svh"
`default_nettype none
module tum_unit_map (
	// clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_reset,
	// table write
	input  wire logic                      i_map_wr,
	input  wire logic [`TUM_IDX_W-1:0]     i_map_idx,
	input  wire tum_pkg::tum_entry_t       i_map_entry,
	// query in
	input  wire logic                      i_qry_valid,
	input  wire logic [`TUM_UNIT_W-1:0]    i_qry_unit,
	// query out
	output var  tum_pkg::tum_query_t       o_tcp,
	// slave outcome
	input  wire logic                      i_rsp_valid,
	input  wire logic [`TUM_IDX_W-1:0]     i_rsp_slot,
	input  wire tum_pkg::tum_rsp_t         i_rsp_kind,
	input  wire logic [`TUM_UNIT_W-1:0]    i_rsp_exc,
	// error read
	input  wire logic [`TUM_IDX_W-1:0]     i_err_sel,
	output var  tum_pkg::tum_err_t         o_err
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	tum_pkg::tum_state_t              state_q;  // registered state
	tum_pkg::tum_state_t              state_d;  // next state
	logic                             hit;      // some valid entry matches
	logic [`TUM_IDX_W-1:0]            hit_idx;  // lowest matching entry
	logic [`TUM_UNIT_W-1:0]           hit_unit; // translated unit

	// -------------------------------------------------------------
	// lookup
	// -------------------------------------------------------------
	// search downward so the lowest-numbered entry wins on overlap
	always_comb begin
		logic [`TUM_UNIT_W-1:0] top;
		top      = '0;
		hit      = 1'b0;
		hit_idx  = '0;
		hit_unit = '0;
		for (int i = `TUM_ENTRIES - 1; i >= 0; i--) begin
			// a range only exists when last exceeds first
			top = (state_q.table_e[i].last_unit > state_q.table_e[i].first_unit) ?
				state_q.table_e[i].last_unit : state_q.table_e[i].first_unit;
			if (state_q.table_e[i].first_unit != `TUM_UNUSED &&
				i_qry_unit >= state_q.table_e[i].first_unit && i_qry_unit <= top) begin
				hit      = 1'b1;
				hit_idx  = `TUM_IDX_W'(i);
				// offset from first unit added to the remap value
				hit_unit = `TUM_UNIT_W'(state_q.table_e[i].remapped_unit +
					(i_qry_unit - state_q.table_e[i].first_unit));
			end
		end
	end

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		// table write from configuration side
		if (i_map_wr && i_map_idx < `TUM_IDX_W'(`TUM_ENTRIES)) begin
			state_d.table_e[i_map_idx] = i_map_entry;
		end
		// query out is a one-cycle pulse
		state_d.qry.valid = 1'b0;
		state_d.qry.drop  = 1'b0;
		if (i_qry_valid) begin
			if (hit) begin
				// address always from the unit lookup
				state_d.qry.valid    = 1'b1;
				state_d.qry.slot     = hit_idx;
				state_d.qry.unit     = hit_unit;
				state_d.qry.ip_addr  = state_q.table_e[hit_idx].ip_addr;
				state_d.qry.tcp_port = state_q.table_e[hit_idx].tcp_port;
			end else begin
				// nothing sent for an unmapped unit
				state_d.qry.drop = 1'b1;
			end
		end
		// outcome of a transaction updates only that slave
		if (i_rsp_valid && i_rsp_slot < `TUM_IDX_W'(`TUM_ENTRIES)) begin
			unique case (i_rsp_kind)
				tum_pkg::TUM_RSP_OK: begin
					// fault resolved, indication goes away
					state_d.err[i_rsp_slot].err_flag = 1'b0;
					state_d.err[i_rsp_slot].exc_code = `TUM_RST_EXC;
				end
				tum_pkg::TUM_RSP_CRC, tum_pkg::TUM_RSP_TIMEOUT: begin
					// saturate rather than wrap to zero
					if (state_q.err[i_rsp_slot].err_count != `TUM_CNT_MAX) begin
						state_d.err[i_rsp_slot].err_count =
							`TUM_CNT_W'(state_q.err[i_rsp_slot].err_count + 1'b1);
					end
					state_d.err[i_rsp_slot].err_flag = 1'b1;
				end
				tum_pkg::TUM_RSP_EXCEPTION: begin
					state_d.err[i_rsp_slot].exc_code = i_rsp_exc;
					state_d.err[i_rsp_slot].err_flag = 1'b1;
				end
			endcase
		end
		// read view of the selected slave
		if (i_err_sel < `TUM_IDX_W'(`TUM_ENTRIES)) begin
			state_d.rd = state_q.err[i_err_sel];
		end else begin
			state_d.rd = '0;
		end
	end

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	// reset empties the table and the error log
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from flip-flops
	assign o_tcp = state_q.qry;
	assign o_err = state_q.rd;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	AST_TABLE_WRITE: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_map_wr && i_map_idx < 5'h14 |=> state_q.table_e[$past(i_map_idx)] == $past(i_map_entry))
		else $error("table entry not written");

	AST_FIRST_REMAP: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_qry_valid && hit && i_qry_unit == state_q.table_e[hit_idx].first_unit
		|=> o_tcp.valid && o_tcp.unit == $past(state_q.table_e[hit_idx].remapped_unit))
		else $error("first unit not replaced by remap value");

	AST_RANGE_OFFSET: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_qry_valid && hit |=> o_tcp.unit == 8'($past(state_q.table_e[hit_idx].remapped_unit)
			+ $past(i_qry_unit) - $past(state_q.table_e[hit_idx].first_unit)))
		else $error("range unit offset wrong");

	AST_IP_LOOKUP: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_qry_valid && hit |=> o_tcp.valid && !o_tcp.drop
			&& o_tcp.ip_addr == $past(state_q.table_e[hit_idx].ip_addr))
		else $error("destination address not from lookup");

	AST_OTHER_SLAVE_STABLE: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot != 5'h00 |=> $stable(state_q.err[0]))
		else $error("outcome leaked into another slave");

	AST_COUNT_BUMP: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot < 5'h14 && (i_rsp_kind == tum_pkg::TUM_RSP_CRC
			|| i_rsp_kind == tum_pkg::TUM_RSP_TIMEOUT) && state_q.err[i_rsp_slot].err_count != 16'hffff
		|=> state_q.err[$past(i_rsp_slot)].err_count == 16'($past(state_q.err[i_rsp_slot].err_count) + 1))
		else $error("error count did not increment");

	AST_EXC_KEEP: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot < 5'h14 && i_rsp_kind == tum_pkg::TUM_RSP_EXCEPTION
		|=> state_q.err[$past(i_rsp_slot)].exc_code == $past(i_rsp_exc)
			&& state_q.err[$past(i_rsp_slot)].err_flag)
		else $error("exception code not stored");

	AST_AUTO_CLEAR: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot < 5'h14 && i_rsp_kind == tum_pkg::TUM_RSP_OK
		|=> !state_q.err[$past(i_rsp_slot)].err_flag)
		else $error("error indication not cleared");

	AST_DROP_UNMAPPED: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_qry_valid && !hit |=> o_tcp.drop && !o_tcp.valid)
		else $error("unmapped query was sent");

	AST_NO_SPURIOUS: assert property (@(posedge i_mclk) disable iff (i_reset)
		!i_qry_valid |=> !o_tcp.valid && !o_tcp.drop)
		else $error("query out without query in");

	// a write aimed past the last entry is refused and changes nothing
	AST_WRITE_REFUSED: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_map_wr && i_map_idx >= 5'h14 |=> $stable(state_q.table_e))
		else $error("write past the table changed an entry");

	// slot and port of a sent query come from the matching entry
	AST_SLOT_FROM_HIT: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_qry_valid && hit |=> o_tcp.slot == $past(hit_idx)
			&& o_tcp.tcp_port == $past(state_q.table_e[hit_idx].tcp_port))
		else $error("slot or port not from lookup");

	// crc and timeout failures raise the indication
	AST_FAIL_FLAG: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot < 5'h14 && (i_rsp_kind == tum_pkg::TUM_RSP_CRC
			|| i_rsp_kind == tum_pkg::TUM_RSP_TIMEOUT)
		|=> state_q.err[$past(i_rsp_slot)].err_flag)
		else $error("failure did not raise the indication");

	// a good answer clears the code but keeps the running count
	AST_OK_KEEPS_COUNT: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_rsp_valid && i_rsp_slot < 5'h14 && i_rsp_kind == tum_pkg::TUM_RSP_OK
		|=> state_q.err[$past(i_rsp_slot)].exc_code == 8'h00
			&& state_q.err[$past(i_rsp_slot)].err_count == $past(state_q.err[i_rsp_slot].err_count))
		else $error("good answer disturbed the error record");

	// read view mirrors the selected slave one cycle later
	AST_READ_VIEW: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_err_sel < 5'h14 |=> o_err == $past(state_q.err[i_err_sel]))
		else $error("read view shows the wrong slave");

	// a selection past the table reads as all zero
	AST_READ_RANGE: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_err_sel >= 5'h14 |=> o_err == 25'h0000000)
		else $error("read past the table not zero");

endmodule
`default_nettype wire

//--- logic/tum_params.svh
// constants of the unit map and error log block
// assumes one clock domain and an includer that wants plain macros
`ifndef TUM_PARAMS_SVH
`define TUM_PARAMS_SVH

`define TUM_ENTRIES   20
`define TUM_IDX_W     5
`define TUM_UNIT_W    8
`define TUM_IP_W      32
`define TUM_PORT_W    16
`define TUM_CNT_W     16
`define TUM_CNT_MAX   16'hffff
`define TUM_UNUSED    8'h00
`define TUM_RST_IP    32'h0000_0000
`define TUM_RST_PORT  16'h0000
`define TUM_RST_EXC   8'h00

`endif

//--- logic/tum_pkg.sv
// types shared by the unit map and error log block
// assumes tum_params.svh is on the include path
`include "tum_params.svh"
`default_nettype none
package tum_pkg;

	// one line of the mapping table
	typedef struct packed {
		logic [`TUM_UNIT_W-1:0] first_unit;    // lower bound, zero marks unused
		logic [`TUM_UNIT_W-1:0] last_unit;     // upper bound of the range
		logic [`TUM_UNIT_W-1:0] remapped_unit; // unit sent for first_unit
		logic [`TUM_IP_W-1:0]   ip_addr;       // destination address
		logic [`TUM_PORT_W-1:0] tcp_port;      // destination port
	} tum_entry_t;

	// outcome of one transaction with a slave
	typedef enum logic [1:0] {
		TUM_RSP_OK,
		TUM_RSP_CRC,
		TUM_RSP_TIMEOUT,
		TUM_RSP_EXCEPTION
	} tum_rsp_t;

	// error record kept per slave
	typedef struct packed {
		logic [`TUM_CNT_W-1:0]  err_count; // crc plus timeout count
		logic [`TUM_UNIT_W-1:0] exc_code;  // latest exception code
		logic                   err_flag;  // error presently indicated
	} tum_err_t;

	// outgoing query toward the network side
	typedef struct packed {
		logic                   valid;
		logic                   drop;
		logic [`TUM_IDX_W-1:0]  slot;
		logic [`TUM_UNIT_W-1:0] unit;
		logic [`TUM_IP_W-1:0]   ip_addr;
		logic [`TUM_PORT_W-1:0] tcp_port;
	} tum_query_t;

	// all state of the block
	typedef struct packed {
		tum_entry_t [`TUM_ENTRIES-1:0] table_e;
		tum_err_t   [`TUM_ENTRIES-1:0] err;
		tum_query_t                    qry;
		tum_err_t                      rd;
	} tum_state_t;

endpackage
`default_nettype wire

//--- tb/tum_slave_model.sv
// partner model: a tcp slave that answers each forwarded query
// assumes the bench picks the outcome kind and exception code
`default_nettype none
module tum_slave_model (
	// clock
	input  wire logic                i_mclk,
	// query leaving the block
	input  wire tum_pkg::tum_query_t i_tcp,
	// outcome wanted next
	input  wire tum_pkg::tum_rsp_t   i_kind,
	input  wire logic [7:0]          i_code,
	// outcome back to the block
	output logic                     o_rsp_valid,
	output logic [4:0]               o_rsp_slot,
	output tum_pkg::tum_rsp_t        o_rsp_kind,
	output logic [7:0]               o_rsp_exc
);
	timeunit 1ns;
	timeprecision 1ns;
	// answer one cycle after a query; idle lines carry junk so stale values never pass
	always @(posedge i_mclk) begin
		o_rsp_valid <= i_tcp.valid;
		o_rsp_slot  <= i_tcp.valid ? i_tcp.slot : 5'h1f;
		o_rsp_kind  <= i_tcp.valid ? i_kind : tum_pkg::tum_rsp_t'(~i_kind);
		o_rsp_exc   <= i_tcp.valid ? i_code : ~i_code;
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the unit map and error log
// assumes tum_pkg is compiled first
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic i_mclk = 1'b0;
	logic i_reset, i_map_wr, i_qry_valid, rsp_valid;
	logic [4:0] i_map_idx, i_err_sel, rsp_slot;
	logic [7:0] i_qry_unit, rsp_exc, code, ex;
	tum_pkg::tum_entry_t i_map_entry;
	tum_pkg::tum_query_t o_tcp;
	tum_pkg::tum_err_t o_err;
	tum_pkg::tum_rsp_t rsp_kind, mode;
	tum_pkg::tum_entry_t tbl [20] = '{default: '0}; // expected table
	logic [15:0] cnt;
	int error_cnt = 0, checks_done = 0, cyc = 0, seed = 6;
	// clock at 25 MHz
	always #20 i_mclk = ~i_mclk;
	tum_unit_map tum_unit_map_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_map_wr(i_map_wr), .i_map_idx(i_map_idx),
		.i_map_entry(i_map_entry), .i_qry_valid(i_qry_valid), .i_qry_unit(i_qry_unit), .o_tcp(o_tcp),
		.i_rsp_valid(rsp_valid), .i_rsp_slot(rsp_slot), .i_rsp_kind(rsp_kind), .i_rsp_exc(rsp_exc),
		.i_err_sel(i_err_sel), .o_err(o_err));
	tum_slave_model tum_slave_model_i (.i_mclk(i_mclk), .i_tcp(o_tcp), .i_kind(mode), .i_code(code),
		.o_rsp_valid(rsp_valid), .o_rsp_slot(rsp_slot), .o_rsp_kind(rsp_kind), .o_rsp_exc(rsp_exc));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// lowest valid entry covering the unit, or -1
	function automatic int hit(input logic [7:0] u);
		hit = -1;
		for (int i = 19; i >= 0; i--)
			if (tbl[i].first_unit != 8'h00 && u >= tbl[i].first_unit && u <= ((tbl[i].last_unit >
				tbl[i].first_unit) ? tbl[i].last_unit : tbl[i].first_unit))
				hit = i;
	endfunction
	// one table write strobe
	task automatic put(input logic [4:0] idx, input tum_pkg::tum_entry_t e);
		@(posedge i_mclk);
		i_map_wr <= 1'b1;
		i_map_idx <= idx;
		i_map_entry <= e;
		@(posedge i_mclk);
		i_map_wr <= 1'b0;
	endtask
	// one query, result checked a cycle later
	task automatic query(input logic [7:0] u);
		int h;
		h = hit(u);
		@(posedge i_mclk);
		i_qry_valid <= 1'b1;
		i_qry_unit <= u;
		@(posedge i_mclk);
		i_qry_valid <= 1'b0;
		#1;
		chk("valid", h >= 0, o_tcp.valid);
		chk("drop", h < 0, o_tcp.drop);
		if (h >= 0) begin
			chk("unit", 8'(tbl[h].remapped_unit + u - tbl[h].first_unit), o_tcp.unit);
			chk("ip", tbl[h].ip_addr, o_tcp.ip_addr);
			chk("port", tbl[h].tcp_port, o_tcp.tcp_port);
			chk("slot", 72'(h), o_tcp.slot);
		end
	endtask
	// hang guard
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{i_reset, i_map_wr, i_map_idx, i_map_entry, i_qry_valid, i_qry_unit, i_err_sel, code} = '0;
		i_reset = 1'b1;
		mode = tum_pkg::TUM_RSP_OK;
		tbl[0] = '{8'h01, 8'h01, 8'h01, 32'hc0a80165, 16'h01f6};
		tbl[1] = '{8'h02, 8'h05, 8'h01, 32'had0b2059, 16'h01f6};
		tbl[2] = '{8'h06, 8'h09, 8'h01, 32'had0b205b, 16'h01f7};
		tbl[3] = '{8'h03, 8'h03, 8'h77, 32'h0a000003, 16'h0010}; // shadowed by entry 1
		tbl[4] = '{8'h0a, 8'h04, 8'h40, 32'h0a000004, 16'h0011}; // covers its first unit only
		tbl[5] = '{8'h00, 8'h14, 8'h99, 32'h0a000005, 16'h0012}; // unused slot
		tbl[19] = '{8'h0d, 8'h0e, 8'hff, 32'h0a000013, 16'h0013}; // remap wraps
		repeat (10) @(posedge i_mclk);
		i_reset <= 1'b0;
		#1;
		chk("tcp reset", 72'h0, o_tcp);
		chk("log reset", 72'h0, o_err);
		for (int i = 0; i < 20; i++)
			put(5'(i), tbl[i]);
		put(5'h14, '{8'h0c, 8'h0c, 8'h01, 32'h0a000020, 16'h0001}); // index past the table
		foreach (tbl[i]) query(8'(i));
		for (int i = 0; i < 60; i++)
			query(8'($random(seed) & 15));
		// outcomes for slave 1 reached through unit 3
		@(posedge i_mclk);
		i_err_sel <= 5'h01;
		cnt = '0;
		ex = '0;
		for (int k = 0; k < 5; k++) begin
			mode <= tum_pkg::tum_rsp_t'(k == 4 ? 0 : (k > 2 ? 3 : k + 1));
			code <= 8'(k * 17 + 8'h20);
			query(8'h03);
			repeat (3) @(posedge i_mclk);
			#1;
			if (k < 2)
				cnt++;
			ex = (k == 2 || k == 3) ? 8'(k * 17 + 8'h20) : (k == 4 ? 8'h00 : ex);
			chk("log", {cnt, ex, k != 4}, o_err);
		end
		@(posedge i_mclk);
		i_err_sel <= 5'h02;
		repeat (2) @(posedge i_mclk);
		#1;
		chk("other slave", 72'h0, o_err);
		// selection past the table aliases slave 1 if decoded wrongly
		@(posedge i_mclk);
		i_err_sel <= 5'h15;
		repeat (2) @(posedge i_mclk);
		#1;
		chk("sel past table", 72'h0, o_err);
		wrap_up();
	end
endmodule
`default_nettype wire
